// ===== pa_pkg.sv
// constants, register map and types for the port a pin control block
package pa_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] PA_OFS_PIN_LEVELS  = 8'h00;
	localparam logic [7:0] PA_OFS_OUT_LATCH   = 8'h04;
	localparam logic [7:0] PA_OFS_DIRECTION   = 8'h08;
	localparam logic [7:0] PA_OFS_ANALOG_CFG  = 8'h0C;
	localparam logic [7:0] PA_OFS_CMP_CTRL    = 8'h10;
	localparam logic [7:0] PA_OFS_CREF_CTRL   = 8'h14;

	// implemented bits per register, everything else reads zero except the comparator result bits 7:6
	localparam logic [7:0] PA_MASK_PORT   = 8'h2F;
	localparam logic [7:0] PA_MASK_LATCH  = 8'h3F;
	localparam logic [7:0] PA_MASK_ANALOG = 8'h3F;
	localparam logic [7:0] PA_MASK_CMP_WR = 8'h3F;

	// reset values
	localparam logic [7:0] PA_RST_LATCH     = 8'h00;
	localparam logic [7:0] PA_RST_DIRECTION = 8'h2F;
	localparam logic [7:0] PA_RST_ANALOG    = 8'h00;
	localparam logic [7:0] PA_RST_CMP       = 8'h07;
	localparam logic [7:0] PA_RST_CREF      = 8'h00;

	// field positions
	localparam int PA_BIT_CREF_OE      = 6;
	localparam int PA_BIT_CMP1_OUT     = 6;
	localparam int PA_BIT_CMP2_OUT     = 7;
	localparam int PA_PIN_CREF         = 2;
	localparam int PA_PIN_CH4          = 5;
	localparam int PA_NUM_CHANNELS     = 5;

	// comparator mode field values
	localparam logic [2:0] PA_CM_OFF         = 3'h7;
	localparam logic [2:0] PA_CM_C2_ROUTED   = 3'h3;

	// analog select: channel n is analog while select plus n stays below this
	localparam logic [4:0] PA_PCFG_LIMIT = 5'h0F;

	// divider for the cycle clock, one quarter of the system clock
	localparam int PA_CYCLE_DIV = 4;

	// bus answer phase
	typedef enum logic {
		PA_BUS_IDLE,
		PA_BUS_ACK
	} pa_bus_state_t;

endpackage

// ===== pa_pin_if.sv
// carrier between the pin synchroniser and the port core
`timescale 1ns/1ps
interface pa_pin_if;
	logic [7:0] pin_raw;
	logic [7:0] pin_lvl;

	// synchroniser side takes raw pins and gives settled levels
	modport sync_side (
		input  pin_raw,
		output pin_lvl
	);
	// core side hands raw pins in and reads the settled levels
	modport core_side (
		output pin_raw,
		input  pin_lvl
	);
endinterface

// ===== pa_pin_sync.sv
// two-stage synchroniser for the port pin inputs
`timescale 1ns/1ps
module pa_pin_sync
	import pa_pkg::*;
(
	// clock and control
	input  wire logic clk_sys_i,
	input  wire logic sys_rst_i,
	input  wire logic ce_i,
	// pin carrier
	pa_pin_if.sync_side pins
);

	logic [7:0] meta_q;
	logic [7:0] lvl_q;

	// first stage is read by the second stage only
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			meta_q <= 8'h00;
			lvl_q  <= 8'h00;
		end else if (ce_i) begin
			meta_q <= pins.pin_raw;
			lvl_q  <= meta_q;
		end
	end

	assign pins.pin_lvl = lvl_q;

endmodule

// ===== pa_port_ctrl.sv
// port a pin control: registers, pin muxing and peripheral overrides
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
module pa_port_ctrl
	import pa_pkg::*;
(
	// clock, reset, enable
	input  wire logic        clk_sys_i,
	input  wire logic        sys_rst_i,
	input  wire logic        ce_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// port pins, three signals each
	input  wire logic [7:0]  port_pin_i,
	output logic      [7:0]  port_pin_o,
	output logic      [7:0]  port_pin_oe_o,
	// oscillator output pin
	input  wire logic        osc_rc_ec_mode_i,
	output logic             cycle_clock_out_o,
	output logic             cycle_clock_out_oe_o,
	// comparator results, same clock domain
	input  wire logic        first_comparator_output_i,
	input  wire logic        second_comparator_output_i,
	// configuration towards converter, comparators and reference
	output logic      [7:0]  analog_pin_config_o,
	output logic      [5:0]  comparator_mode_o,
	output logic      [7:0]  comparator_reference_control_o,
	output logic      [4:0]  analog_channel_mask_o,
	output logic             reference_output_enable_o,
	// serial port slave select
	output logic             serial_slave_select_o
);

	////////////////////////////////////////////////////////////////////////
	// decode helpers

	// true when converter channel n is selected as analog
	function automatic logic pa_is_analog(input logic [3:0] pcfg, input int n);
		logic [4:0] sum;
		sum = {1'b0, pcfg} + 5'(n);
		return sum < PA_PCFG_LIMIT;
	endfunction

	// converter channel number to port pin index
	function automatic int pa_chan_pin(input int n);
		return (n == 4) ? PA_PIN_CH4 : n;
	endfunction

	// register bus hit test
	function automatic logic pa_hit(input logic [7:0] adr, input logic [7:0] ofs);
		return adr == ofs;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// declarations

	pa_pin_if pins ();

	pa_bus_state_t bus_q;
	pa_bus_state_t bus_d;

	logic [7:0]  latch_q;
	logic [7:0]  dir_q;
	logic [7:0]  analog_q;
	logic [5:0]  cmp_q;
	logic [7:0]  cref_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0]  div_q;
	logic        cclk_q;

	logic [7:0]  analog_pins;
	logic [7:0]  dig_in_off;
	logic [7:0]  port_read;
	logic [7:0]  cmp_read;
	logic        req;
	logic        wr_go;
	logic        cref_oe;
	logic        c2_routed;
	logic        cmp_on;

	////////////////////////////////////////////////////////////////////////
	// design notes for the next engineer
	//
	// the register bus answers every request one cycle after taking it and
	// then forces one idle cycle, so a master that holds stb after the ack
	// gets a second, separate answer rather than a stretched one.
	//
	// writes land on the edge where the master samples ack high; read data
	// is captured one edge earlier, so it stands for the whole ack cycle.
	//
	// pin levels pass two flops before any logic reads them, so a port read
	// shows a pad change two edges late, plus one edge for the capture.
	//
	// the drivers follow the direction bits and the reference and comparator overrides; selecting a pin as analog
	// never changes what is driven, which is why software keeps them set.
	//
	// the reference output and the comparator override are combinational on
	// purpose: a registered override would put one stale cycle on the pad.
	//
	// clock enable low freezes every flop, the bus state included, so a
	// master must not time out on a frozen block.
	//
	// unimplemented register bits are masked both on write and on read; the
	// masks live in the package so the two paths cannot drift apart.
	//
	// the cycle clock divider runs freely; only its output is gated by mode,
	// so the phase after a mode change is not defined.

	////////////////////////////////////////////////////////////////////////
	// pin input synchronisation

	assign pins.pin_raw = port_pin_i;

	pa_pin_sync u_sync (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.pins      (pins.sync_side)
	);

	////////////////////////////////////////////////////////////////////////
	// configuration decode

	// map the analog select onto port pins
	always_comb begin
		analog_pins = 8'h00;
		for (int n = 0; n < PA_NUM_CHANNELS; n++) begin
			analog_pins[pa_chan_pin(n)] = pa_is_analog(analog_q[3:0], n);
		end
	end

	// exported channel mask follows the same decode
	always_comb begin
		analog_channel_mask_o = 5'h00;
		for (int n = 0; n < PA_NUM_CHANNELS; n++) begin
			analog_channel_mask_o[n] = pa_is_analog(analog_q[3:0], n);
		end
	end

	assign cref_oe   = cref_q[PA_BIT_CREF_OE];
	assign c2_routed = (cmp_q[2:0] == PA_CM_C2_ROUTED);
	// comparator inputs sit on pins 0..3 unless the comparators are off
	assign cmp_on    = (cmp_q[2:0] != PA_CM_OFF);

	// digital input is cut on analog pins and on the reference pin
	always_comb begin
		dig_in_off = analog_pins;
		if (cmp_on) begin
			dig_in_off[3:0] = 4'hF;
		end
		if (cref_oe) begin
			dig_in_off[PA_PIN_CREF] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drivers

	// drivers follow direction, reference enable and comparator routing, analog selection is ignored on purpose
	always_comb begin
		port_pin_oe_o = ~dir_q & PA_MASK_PORT;
		if (cref_oe) begin
			port_pin_oe_o[PA_PIN_CREF] = 1'b0;
		end
		port_pin_o = latch_q & PA_MASK_PORT;
		if (c2_routed) begin
			port_pin_o[PA_PIN_CH4] = second_comparator_output_i;
		end
	end

	// slave select idles high when the pin is an output
	assign serial_slave_select_o = dir_q[PA_PIN_CH4] ?
		pins.pin_lvl[PA_PIN_CH4] : 1'b1;

	////////////////////////////////////////////////////////////////////////
	// cycle clock on the oscillator pin

	// free counter; clock output is the top bit, a quarter of the rate
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			div_q <= 2'h0;
		end else if (ce_i) begin
			div_q <= div_q + 2'h1;
		end
	end

	// registered so the pin never sees a decode glitch
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			cclk_q <= 1'b0;
		end else if (ce_i) begin
			cclk_q <= div_q[1] & osc_rc_ec_mode_i;
		end
	end

	// driven regardless of any direction bit
	assign cycle_clock_out_o    = cclk_q;
	assign cycle_clock_out_oe_o = osc_rc_ec_mode_i;

	////////////////////////////////////////////////////////////////////////
	// read values

	// analog and reference pins read zero, not the pad level
	assign port_read = pins.pin_lvl & ~dig_in_off & PA_MASK_PORT;

	// comparator results are read only, upper two bits
	assign cmp_read = {second_comparator_output_i, first_comparator_output_i, cmp_q};

	////////////////////////////////////////////////////////////////////////
	// wishbone slave

	assign req   = wb_cyc_i & wb_stb_i;
	// writes land on the edge where the master sees ack
	assign wr_go = req & wb_we_i & wb_sel_i[0] & (bus_q == PA_BUS_ACK);

	// one request, one ack, then a forced idle cycle
	always_comb begin
		case (bus_q)
			PA_BUS_IDLE: begin
				bus_d = req ? PA_BUS_ACK : PA_BUS_IDLE;
			end
			PA_BUS_ACK: begin
				bus_d = PA_BUS_IDLE;
			end
			default: begin
				bus_d = PA_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			bus_q <= PA_BUS_IDLE;
		end else if (ce_i) begin
			bus_q <= bus_d;
		end
	end

	assign wb_ack_o = (bus_q == PA_BUS_ACK);

	// read mux, unmapped addresses answer zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (pa_hit(wb_adr_i, PA_OFS_PIN_LEVELS)) begin
			rdata_d[7:0] = port_read;
		end else if (pa_hit(wb_adr_i, PA_OFS_OUT_LATCH)) begin
			rdata_d[7:0] = latch_q & PA_MASK_LATCH;
		end else if (pa_hit(wb_adr_i, PA_OFS_DIRECTION)) begin
			rdata_d[7:0] = dir_q & PA_MASK_PORT;
		end else if (pa_hit(wb_adr_i, PA_OFS_ANALOG_CFG)) begin
			rdata_d[7:0] = analog_q & PA_MASK_ANALOG;
		end else if (pa_hit(wb_adr_i, PA_OFS_CMP_CTRL)) begin
			rdata_d[7:0] = cmp_read;
		end else if (pa_hit(wb_adr_i, PA_OFS_CREF_CTRL)) begin
			rdata_d[7:0] = cref_q;
		end
	end

	// read data captured as the ack is raised
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (ce_i && req && bus_q == PA_BUS_IDLE) begin
			rdata_q <= rdata_d;
		end
	end

	assign wb_dat_o = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// registers

	// output latch, reached by both the port and the latch address
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			latch_q <= PA_RST_LATCH;
		end else if (ce_i && wr_go) begin
			if (pa_hit(wb_adr_i, PA_OFS_PIN_LEVELS)) begin
				latch_q <= wb_dat_i[7:0] & PA_MASK_LATCH;
			end else if (pa_hit(wb_adr_i, PA_OFS_OUT_LATCH)) begin
				latch_q <= wb_dat_i[7:0] & PA_MASK_LATCH;
			end
		end
	end

	// direction, all implemented pins come up as inputs
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			dir_q <= PA_RST_DIRECTION;
		end else if (ce_i && wr_go && pa_hit(wb_adr_i, PA_OFS_DIRECTION)) begin
			dir_q <= wb_dat_i[7:0] & PA_MASK_PORT;
		end
	end

	// analog select resets to all five channels analog
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			analog_q <= PA_RST_ANALOG;
		end else if (ce_i && wr_go && pa_hit(wb_adr_i, PA_OFS_ANALOG_CFG)) begin
			analog_q <= wb_dat_i[7:0] & PA_MASK_ANALOG;
		end
	end

	// comparator control, result bits are not stored
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			cmp_q <= PA_RST_CMP[5:0];
		end else if (ce_i && wr_go && pa_hit(wb_adr_i, PA_OFS_CMP_CTRL)) begin
			cmp_q <= wb_dat_i[5:0] & PA_MASK_CMP_WR[5:0];
		end
	end

	// reference control
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			cref_q <= PA_RST_CREF;
		end else if (ce_i && wr_go && pa_hit(wb_adr_i, PA_OFS_CREF_CTRL)) begin
			cref_q <= wb_dat_i[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration outputs

	assign analog_pin_config_o           = analog_q;
	assign comparator_mode_o             = cmp_q;
	assign comparator_reference_control_o = cref_q;
	assign reference_output_enable_o     = cref_oe;

endmodule

// ===== pa_pin_model.sv
// external circuitry model on the port pins
`timescale 1ns/1ps
module pa_pin_model (
	// pad side of the block
	input  wire logic [7:0] pin_drv_i,
	input  wire logic [7:0] pin_oe_i,
	// level the outside circuit tries to force
	input  wire logic [7:0] ext_lvl_i,
	// resolved pad level
	output logic      [7:0] pad_o
);
	// block wins where it drives; contention is not modelled
	assign pad_o = (pin_oe_i & pin_drv_i) | (~pin_oe_i & ext_lvl_i);
endmodule

// ===== pa_port_ctrl_chk.sv
// port relation checker bound to the pin control top
`timescale 1ns/1ps
module pa_port_ctrl_chk
	import pa_pkg::*;
(
	// clock and reset
	input wire logic        clk_sys_i,
	input wire logic        sys_rst_i,
	// bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	// pins and peripheral hooks
	input wire logic [7:0]  port_pin_i,
	input wire logic [7:0]  port_pin_o,
	input wire logic [7:0]  port_pin_oe_o,
	input wire logic        osc_rc_ec_mode_i,
	input wire logic        cycle_clock_out_o,
	input wire logic        cycle_clock_out_oe_o,
	input wire logic        second_comparator_output_i,
	input wire logic [5:0]  comparator_mode_o,
	input wire logic [4:0]  analog_channel_mask_o,
	input wire logic        reference_output_enable_o,
	input wire logic        serial_slave_select_o
);
	// one domain, so clock and reset are given once
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	//////////////////////////////////////////
	// bus answer timing
	a_ack_latency: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
		else $error("ack not one cycle after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack wider than one cycle");
	a_rdata_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	// pin muxing and overrides
	a_reset_analog: assert property ($past(sys_rst_i) |-> analog_channel_mask_o == 5'h1F && port_pin_oe_o == 8'h00)
		else $error("reset pin state wrong");
	a_cref_kill: assert property (reference_output_enable_o |-> !port_pin_oe_o[2])
		else $error("reference pin still driven");
	a_c2_override: assert property (comparator_mode_o[2:0] == PA_CM_C2_ROUTED && port_pin_oe_o[5] |-> port_pin_o[5] == second_comparator_output_i)
		else $error("comparator output not on pin");
	a_ss_follow: assert property (!port_pin_oe_o[5] [*3] |-> serial_slave_select_o == $past(port_pin_i[5], 2))
		else $error("slave select not following pin");
	a_ss_output: assert property (port_pin_oe_o[5] |-> serial_slave_select_o)
		else $error("slave select active on output pin");
	// cycle clock output
	a_clk_oe: assert property (cycle_clock_out_oe_o == osc_rc_ec_mode_i)
		else $error("cycle clock enable wrong");
	a_clk_div: assert property (osc_rc_ec_mode_i [*6] |-> cycle_clock_out_o != $past(cycle_clock_out_o, 2))
		else $error("cycle clock not divide by four");
endmodule
bind pa_port_ctrl pa_port_ctrl_chk chk_u (.clk_sys_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .wb_dat_o, .port_pin_i, .port_pin_o, .port_pin_oe_o, .osc_rc_ec_mode_i,
	.cycle_clock_out_o, .cycle_clock_out_oe_o, .second_comparator_output_i,
	.comparator_mode_o, .analog_channel_mask_o, .reference_output_enable_o,
	.serial_slave_select_o);

// ===== pa_port_ctrl_bench.sv
// self-checking bench for the port pin control block
`timescale 1ns/1ps
module pa_port_ctrl_bench
	import pa_pkg::*;
;
	localparam logic [7:0] RST_V [6] = '{8'h00, 8'h00, 8'h2F, 8'h00, 8'h07, 8'h00};
	logic clk_sys_i = 0, sys_rst_i = 1, cyc = 0, stb = 0, we = 0, mode = 0, c1 = 0, c2 = 0;
	logic [7:0] adr = 8'h00, ext = 8'h00;
	logic [31:0] dat = 32'h0, rq;
	wire logic ack, cko, ckoe, refoe, ss;
	wire logic [31:0] rdat;
	wire logic [7:0] pin_i, pin_o, oe, acfg, crv;
	wire logic [4:0] amask;
	int err_total = 0, checks_done = 0, n;
	// 200 MHz system clock
	always #2.5 clk_sys_i = ~clk_sys_i;
	//////////////////////////////////////////
	pa_port_ctrl dut_u (.clk_sys_i, .sys_rst_i, .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .port_pin_i(pin_i), .port_pin_o(pin_o), .port_pin_oe_o(oe),
		.osc_rc_ec_mode_i(mode), .cycle_clock_out_o(cko), .cycle_clock_out_oe_o(ckoe),
		.first_comparator_output_i(c1), .second_comparator_output_i(c2),
		.analog_pin_config_o(acfg), .comparator_mode_o(), .comparator_reference_control_o(crv),
		.analog_channel_mask_o(amask), .reference_output_enable_o(refoe),
		.serial_slave_select_o(ss));
	pa_pin_model pins_u (.pin_drv_i(pin_o), .pin_oe_i(oe), .ext_lvl_i(ext), .pad_o(pin_i));
	//////////////////////////////////////////
	// compare and count
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// classic cycle; waits for ack, then one idle cycle so writes have landed
	task bus(input logic [7:0] a, input logic [7:0] d, input logic w);
		int k;
		k = 0;
		@(posedge clk_sys_i);
		{cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, 24'h0, d};
		do begin
			@(posedge clk_sys_i);
			k++;
		end while (ack !== 1'b1 && k < 40);
		if (ack !== 1'b1) begin
			err_total++;
			complete_run;
		end
		rq = rdat;
		{cyc, stb, we} <= 3'h0;
		@(posedge clk_sys_i);
		#1;
	endtask
	task rc(input logic [7:0] a, input logic [7:0] e);
		bus(a, 8'h00, 1'b0);
		chk(rq, {24'h0, e});
	endtask
	task complete_run;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// hang guard, far beyond the roughly 160 cycles the tests need
	initial begin
		#50000;
		err_total++;
		complete_run;
	end
	// test sequence
	initial begin
		repeat (10) @(posedge clk_sys_i);
		{sys_rst_i, ext} <= {1'b0, 8'hFF};
		@(posedge clk_sys_i);
		#1;
		chk(amask, 5'h1F);
		chk({cko, ckoe}, 2'b00);
		for (int i = 0; i < 6; i++) rc(8'(i * 4), RST_V[i]);
		bus(8'h18, 8'h55, 1'b1);
		rc(8'h18, 8'h00);
		bus(8'h0C, 8'h0F, 1'b1);
		chk(amask, 5'h00);
		chk(acfg, 8'h0F);
		rc(8'h00, 8'h2F);
		bus(8'h00, 8'hFF, 1'b1);
		rc(8'h04, 8'h3F);
		bus(8'h08, 8'h00, 1'b1);
		@(posedge clk_sys_i) ext <= 8'h00;
		chk(pin_o & oe, 8'h2F);
		rc(8'h00, 8'h2F);
		bus(8'h0C, 8'h00, 1'b1);
		chk(pin_o & oe, 8'h2F);
		rc(8'h00, 8'h00);
		bus(8'h0C, 8'h0F, 1'b1);
		bus(8'h14, 8'h40, 1'b1);
		chk({refoe, oe}, 9'h12B);
		chk(crv, 8'h40);
		@(posedge clk_sys_i) ext <= 8'hFF;
		bus(8'h08, 8'h2F, 1'b1);
		rc(8'h00, 8'h2B);
		bus(8'h14, 8'h00, 1'b1);
		bus(8'h08, 8'h00, 1'b1);
		bus(8'h04, 8'h1F, 1'b1);
		bus(8'h10, 8'h03, 1'b1);
		for (int v = 0; v < 2; v++) begin
			@(posedge clk_sys_i) {c1, c2} <= {2{v[0]}};
			#1;
			chk(pin_o[5], v[0]);
		end
		rc(8'h10, 8'hC3);
		bus(8'h10, 8'h07, 1'b1);
		bus(8'h08, 8'h2F, 1'b1);
		for (int v = 0; v < 2; v++) begin
			@(posedge clk_sys_i) ext <= {8{v[0]}};
			repeat (4) @(posedge clk_sys_i);
			#1;
			chk(ss, v[0]);
		end
		// direction left as inputs: the clock must not care
		@(posedge clk_sys_i) mode <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		n = 0;
		repeat (16) begin
			@(posedge clk_sys_i);
			#1;
			if (cko === 1'b1) n++;
		end
		chk(n, 8);
		chk(ckoe, 1'b1);
		complete_run;
	end
endmodule
